// file: rtl/adcms_buf.sv
// adcms_buf: small result buffer with valid/ready on both sides.
// assumes: both sides on core_clk; rst_n synchronous, active low.
`timescale 1ns/1ns
`default_nettype none

module adcms_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire  [CW-1:0]    next_count = count + CW'(push) - CW'(pop);

  // ready is honest: low whenever every entry is occupied
  assign in_ready = (count != CW'(DEPTH));
  assign out_data = mem[rd_ptr];

  // pointer step with wrap for depths that are not powers of two
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : step

  // storage and occupancy; valid is kept in a flop of its own
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= step(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= step(rd_ptr);
      end
      count     <= next_count;
      out_valid <= (next_count != '0);
    end
  end

endmodule : adcms_buf
`default_nettype wire

// file: rtl/adcms_defs.svh
// adcms_defs.svh: offsets, field positions, reset values and cycle counts
// for the serial mode sequencer of the converter.
// assumes: included by bare name from files under rtl/; definitions only.
`ifndef ADCMS_DEFS_SVH
`define ADCMS_DEFS_SVH

// ----------------------------------------------------------------------------
// control byte field positions, counted in serial clocks after the start bit
// ----------------------------------------------------------------------------
`define ADCMS_POS_RANGE    6'h01
`define ADCMS_POS_CLK      6'h02
`define ADCMS_POS_MODE_UP  6'h03
`define ADCMS_POS_MODE_LO  6'h04

// ----------------------------------------------------------------------------
// acquisition and conversion lengths in serial clocks
// ----------------------------------------------------------------------------
`define ADCMS_ACQ_SHORT    6'h05
`define ADCMS_TOTAL_SHORT  6'h18
`define ADCMS_ACQ_LONG     6'h0D
`define ADCMS_TOTAL_LONG   6'h20
`define ADCMS_ACQ_START    6'h01

// ----------------------------------------------------------------------------
// calibration length in conversion clocks, range coding, reset values
// ----------------------------------------------------------------------------
`define ADCMS_CAL_W        17
`define ADCMS_CAL_CYCLES   17'h13880
`define ADCMS_RANGE_UNI    1'h1
`define ADCMS_RST_RANGE    1'h1
`define ADCMS_CODE_W       16
`define ADCMS_BUF_DEPTH    2

`endif

// file: rtl/adcms_pkg.sv
// adcms_pkg: types used by the mode sequencer; its result buffer uses none of them.
// assumes: constants come from adcms_defs.svh; nothing here is imported.
package adcms_pkg;

  // ----------------------------------------------------------------------------
  // mode field of the control byte
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCMS_MODE_SHORT = 2'h0,
    ADCMS_MODE_CAL   = 2'h1,
    ADCMS_MODE_SWPD  = 2'h2,
    ADCMS_MODE_LONG  = 2'h3
  } adcms_mode_type;

  // ----------------------------------------------------------------------------
  // operating state of the core side
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCMS_ST_IDLE  = 2'b00,
    ADCMS_ST_CAL   = 2'b01,
    ADCMS_ST_SWPD  = 2'b10,
    ADCMS_ST_PINPD = 2'b11
  } adcms_state_type;

  // fields of one control byte handed from the link side to the core side
  typedef struct packed {
    logic           range_polarity_bit;
    logic           clk_internal;
    adcms_mode_type mode;
  } adcms_ctrl_type;

endpackage : adcms_pkg

// file: rtl/adcms_seq.sv
// adcms_seq: mode sequencer of a serially controlled 16-bit converter.
// assumes: sclk is made by the host and may stop between bytes; the host
// leaves at least 0.5 us between control bytes; sample_code comes from the
// analog core on core_clk as offset binary.
`include "adcms_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module adcms_seq #(
  parameter int unsigned CAL_CYCLES = `ADCMS_CAL_CYCLES,
  parameter int          CODE_W     = `ADCMS_CODE_W,
  parameter int          BUF_DEPTH  = `ADCMS_BUF_DEPTH
) (
  // core clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // serial link from the host
  input  wire logic              sclk,
  input  wire logic              din,
  // pins
  input  wire logic              power_down_pin_n,
  output logic                   serial_strobe_out,
  // analog core
  input  wire logic [CODE_W-1:0] sample_code,
  output logic                   acquiring,
  output logic                   range_bipolar,
  output logic                   powered_down,
  output logic                   cal_busy,
  // results
  output logic                   result_valid,
  input  wire logic              result_ready,
  output logic      [CODE_W-1:0] result_data
);

  // ----------------------------------------------------------------------------
  // link side, clocked by sclk
  // ----------------------------------------------------------------------------
  logic                   srst_s1;
  logic                   srst_s2;
  logic                   busy;
  logic [5:0]             cnt;
  logic                   range_act;
  logic                   clk_int_l;
  logic                   mode_up_l;
  logic                   long_sel;
  logic                   last_long;
  logic                   acq_l;
  logic                   start_tgl;
  logic                   done_tgl;
  logic                   cal_tgl;
  logic                   cal_int_l;
  adcms_pkg::adcms_ctrl_type byte_ctrl;
  adcms_pkg::adcms_ctrl_type done_ctrl;

  // core reset carried into the link domain
  always_ff @(posedge sclk) begin
    srst_s1 <= rst_n;
    srst_s2 <= srst_s1;
  end

  // decode of the serial counter
  wire                        start_det = !busy && din;
  wire                        mode_edge = busy && (cnt == `ADCMS_POS_MODE_LO);
  wire adcms_pkg::adcms_mode_type mode_in = adcms_pkg::adcms_mode_type'({mode_up_l, din});
  wire                        is_cal    = (mode_in == adcms_pkg::ADCMS_MODE_CAL);
  wire                        long_in   = (mode_in == adcms_pkg::ADCMS_MODE_LONG) ||
                                          ((mode_in == adcms_pkg::ADCMS_MODE_SWPD) && last_long);
  wire [5:0]                  end_cnt   = long_sel ? (`ADCMS_TOTAL_LONG - 6'h01)
                                                   : (`ADCMS_TOTAL_SHORT - 6'h01);
  wire [5:0]                  acq_end   = `ADCMS_ACQ_START +
                                          (long_sel ? `ADCMS_ACQ_LONG : `ADCMS_ACQ_SHORT);
  wire                        end_hit   = busy && (cnt == end_cnt);

  // control byte capture and conversion timing; cnt 0 is the start bit
  always_ff @(posedge sclk) begin
    if (!srst_s2) begin
      busy      <= 1'b0;
      cnt       <= 6'h00;
      range_act <= `ADCMS_RST_RANGE;
      clk_int_l <= 1'b0;
      mode_up_l <= 1'b0;
      long_sel  <= 1'b0;
      last_long <= 1'b0;
      acq_l     <= 1'b0;
      start_tgl <= 1'b0;
      done_tgl  <= 1'b0;
      cal_tgl   <= 1'b0;
      cal_int_l <= 1'b0;
      byte_ctrl <= '0;
      done_ctrl <= '0;
    end else if (start_det) begin
      busy      <= 1'b1;
      cnt       <= 6'h01;
      acq_l     <= 1'b1;
      start_tgl <= ~start_tgl;
    end else if (busy) begin
      cnt <= cnt + 6'h01;
      if (cnt == `ADCMS_POS_RANGE) range_act <= din;
      if (cnt == `ADCMS_POS_CLK) clk_int_l <= din;
      if (cnt == `ADCMS_POS_MODE_UP) mode_up_l <= din;
      if (cnt == acq_end) acq_l <= 1'b0;
      if (mode_edge) begin
        long_sel  <= long_in;
        byte_ctrl <= '{range_act, clk_int_l, mode_in};
        if (is_cal) begin
          busy      <= 1'b0;
          acq_l     <= 1'b0;
          cal_int_l <= clk_int_l;
          cal_tgl   <= ~cal_tgl;
        end
      end
      if (end_hit && !mode_edge) begin
        busy      <= 1'b0;
        last_long <= long_sel;
        done_ctrl <= byte_ctrl;
        done_tgl  <= ~done_tgl;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // crossing into core_clk: toggles for events, two flops for levels
  // ----------------------------------------------------------------------------
  logic [2:0] tg_s1;
  logic [2:0] tg_s2;
  logic [2:0] tg_s3;
  logic [1:0] lv_s1;
  logic [1:0] lv_s2;
  logic       pin_s1;
  logic       pin_s2;

  always_ff @(posedge core_clk) begin
    tg_s1  <= {start_tgl, done_tgl, cal_tgl};
    tg_s2  <= tg_s1;
    tg_s3  <= tg_s2;
    lv_s1  <= {acq_l, range_act};
    lv_s2  <= lv_s1;
    pin_s1 <= power_down_pin_n;
    pin_s2 <= pin_s1;
  end

  // event pulses; the link-side words they announce are stable by then
  wire evt_start = tg_s2[2] ^ tg_s3[2];
  wire evt_done  = tg_s2[1] ^ tg_s3[1];
  wire evt_cal   = tg_s2[0] ^ tg_s3[0];
  wire pin_up    = pin_s2;

  // ----------------------------------------------------------------------------
  // core state machine: calibration and power-down
  // ----------------------------------------------------------------------------
  adcms_pkg::adcms_state_type state;
  adcms_pkg::adcms_state_type next_state;
  logic [`ADCMS_CAL_W-1:0]    cal_cnt;
  logic                       cal_int;

  wire cal_last = (cal_cnt == `ADCMS_CAL_W'(1));
  wire done_swpd = evt_done && (done_ctrl.mode == adcms_pkg::ADCMS_MODE_SWPD);
  wire next_cal_int = evt_cal ? cal_int_l : cal_int;

  // a new calibration request outranks the start bit of its own byte
  always_comb begin
    next_state = state;
    case (state)
      adcms_pkg::ADCMS_ST_IDLE: begin
        if (!pin_up) next_state = adcms_pkg::ADCMS_ST_PINPD;
        else if (evt_cal) next_state = adcms_pkg::ADCMS_ST_CAL;
        else if (done_swpd) next_state = adcms_pkg::ADCMS_ST_SWPD;
      end
      adcms_pkg::ADCMS_ST_CAL: begin
        if (!pin_up) next_state = adcms_pkg::ADCMS_ST_PINPD;
        else if (evt_cal) next_state = adcms_pkg::ADCMS_ST_CAL;
        else if (evt_start) next_state = adcms_pkg::ADCMS_ST_IDLE;
        else if (cal_last) next_state = adcms_pkg::ADCMS_ST_IDLE;
      end
      adcms_pkg::ADCMS_ST_SWPD: begin
        if (!pin_up) next_state = adcms_pkg::ADCMS_ST_PINPD;
        else if (evt_cal) next_state = adcms_pkg::ADCMS_ST_CAL;
        else if (evt_start) next_state = adcms_pkg::ADCMS_ST_IDLE;
      end
      adcms_pkg::ADCMS_ST_PINPD: begin
        if (pin_up) next_state = adcms_pkg::ADCMS_ST_IDLE;
      end
      default: next_state = adcms_pkg::ADCMS_ST_IDLE;
    endcase
  end

  // state, calibration counter and pin-facing levels
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state             <= adcms_pkg::ADCMS_ST_IDLE;
      cal_cnt           <= '0;
      cal_int           <= 1'b0;
      serial_strobe_out <= 1'b0;
      powered_down      <= 1'b0;
      cal_busy          <= 1'b0;
      acquiring         <= 1'b0;
      range_bipolar     <= 1'b0;
    end else begin
      state   <= next_state;
      cal_int <= next_cal_int;
      if (evt_cal) cal_cnt <= `ADCMS_CAL_W'(CAL_CYCLES);
      else if (state == adcms_pkg::ADCMS_ST_CAL) cal_cnt <= cal_cnt - 1'b1;
      // strobe idles at the opposite level of its calibration level
      serial_strobe_out <= (next_state == adcms_pkg::ADCMS_ST_CAL) ^ next_cal_int;
      powered_down <= next_state[1];
      cal_busy     <= (next_state == adcms_pkg::ADCMS_ST_CAL);
      acquiring    <= lv_s2[1];
      range_bipolar <= (lv_s2[0] != `ADCMS_RANGE_UNI);
    end
  end

  // ----------------------------------------------------------------------------
  // result formatting and buffering
  // ----------------------------------------------------------------------------
  logic              pend_valid;
  logic [CODE_W-1:0] pend_data;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [CODE_W-1:0] buf_out_data;

  // in bipolar range, offset binary from the array becomes two's complement by the sign flip
  function automatic logic [CODE_W-1:0] fmt_code(input logic [CODE_W-1:0] c,
                                                  input logic uni);
    fmt_code = uni ? c : {~c[CODE_W-1], c[CODE_W-2:0]};
  endfunction : fmt_code

  wire uni_done = (done_ctrl.range_polarity_bit == `ADCMS_RANGE_UNI);

  // one word waits here while the buffer is full; a newer one replaces it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_data  <= '0;
    end else if (evt_done) begin
      pend_valid <= 1'b1;
      pend_data  <= fmt_code(sample_code, uni_done);
    end else if (buf_in_ready) begin
      pend_valid <= 1'b0;
    end
  end

  adcms_buf #(
    .WIDTH (CODE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (pend_valid),
    .in_ready  (buf_in_ready),
    .in_data   (pend_data),
    .out_valid (buf_out_valid),
    .out_ready (result_ready),
    .out_data  (buf_out_data)
  );

  assign result_valid = buf_out_valid;
  assign result_data  = buf_out_data;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  sequence s_cal_running;
    (state == adcms_pkg::ADCMS_ST_CAL) && pin_up && !evt_cal;
  endsequence

  a_short_total: assert property (@(posedge sclk) disable iff (!srst_s2)
    end_hit && !long_sel |-> cnt == 6'd23)
    else $error("short conversion did not end at 24 clocks");

  a_long_total: assert property (@(posedge sclk) disable iff (!srst_s2)
    end_hit && long_sel |-> cnt == 6'd31)
    else $error("long conversion did not end at 32 clocks");

  a_short_sample: assert property (@(posedge sclk) disable iff (!srst_s2)
    busy && cnt == 6'd6 && !long_sel |=> !acq_l)
    else $error("short acquisition still open after sixth clock");

  a_long_acq_open: assert property (@(posedge sclk) disable iff (!srst_s2)
    busy && cnt == 6'd13 && long_sel |=> acq_l)
    else $error("long acquisition closed too early");

  a_swpd_length: assert property (@(posedge sclk) disable iff (!srst_s2)
    mode_edge && mode_in == adcms_pkg::ADCMS_MODE_SWPD |=> long_sel == $past(last_long))
    else $error("shutdown conversion changed acquisition length");

  a_range_switch: assert property (@(posedge sclk) disable iff (!srst_s2)
    busy && !start_det && cnt == 6'd1 |=> range_act == $past(din))
    else $error("range not taken from second bit");

  a_cal_enter: assert property (@(posedge core_clk) disable iff (!rst_n)
    evt_cal && pin_up |=> state == adcms_pkg::ADCMS_ST_CAL ##0 cal_busy)
    else $error("calibration request not taken");

  a_cal_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_cal_running ##0 evt_start |=> state == adcms_pkg::ADCMS_ST_IDLE)
    else $error("start bit did not abort calibration");

  a_cal_finish: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_cal_running ##0 !evt_start && cal_last |=> state == adcms_pkg::ADCMS_ST_IDLE)
    else $error("calibration did not finish on count");

  a_pin_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pin_up |=> powered_down && state == adcms_pkg::ADCMS_ST_PINPD)
    else $error("power-down pin not obeyed");

  a_sw_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == adcms_pkg::ADCMS_ST_SWPD && pin_up && evt_start && !evt_cal
      |=> state == adcms_pkg::ADCMS_ST_IDLE ##1 !powered_down)
    else $error("start bit did not wake from software power-down");

  a_strobe_cal: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == adcms_pkg::ADCMS_ST_CAL && $past(state) == adcms_pkg::ADCMS_ST_CAL
      |-> serial_strobe_out == !cal_int)
    else $error("strobe level wrong during calibration");

  a_code_format: assert property (@(posedge core_clk) disable iff (!rst_n)
    evt_done |=> pend_data == (uni_done ? $past(sample_code)
                 : {~$past(sample_code[CODE_W-1]), $past(sample_code[CODE_W-2:0])}))
    else $error("result coding does not follow range");

endmodule : adcms_seq
`default_nettype wire

// file: verif/adc_serial_mode_sequencer_tb.sv
// adc_serial_mode_sequencer_tb: self-checking bench of the mode sequencer.
// assumes: adcms_host drives the link; calibration shortened to 20 clocks.
`timescale 1ns/1ns
`default_nettype none

module adc_serial_mode_sequencer_tb;
  typedef struct packed {
    logic [3:0]  hdr;
    logic [5:0]  len;
    logic [15:0] code;
    logic [15:0] exp;
    logic        lng;
  } adcms_row_type;

  logic          core_clk         = 1'b0;
  logic          rst_n            = 1'b0;
  logic          power_down_pin_n = 1'b1;
  logic          result_ready     = 1'b1;
  logic [15:0]   sample_code      = 16'h0000;
  logic          start            = 1'b0;
  logic [3:0]    hdr              = 4'h0;
  logic [5:0]    nclk             = 6'h04;
  wire logic     sclk, din, busy, serial_strobe_out, acquiring;
  wire logic     range_bipolar, powered_down, cal_busy, result_valid;
  wire logic [15:0] result_data;
  int            fail_count = 0;
  int            checks = 0;
  int            acq_n = 0;
  int            n;
  int            k;
  adcms_row_type rows [5];

  // 100 ns core clock
  always #50 core_clk = ~core_clk;

  // width of each acquisition window, counted in core clocks
  always @(negedge core_clk) if (acquiring === 1'b1) acq_n++;

  adcms_seq #(.CAL_CYCLES(20)) adcms_seq_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .din(din),
    .power_down_pin_n(power_down_pin_n), .serial_strobe_out(serial_strobe_out),
    .sample_code(sample_code), .acquiring(acquiring), .range_bipolar(range_bipolar),
    .powered_down(powered_down), .cal_busy(cal_busy), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data));

  adcms_host adcms_host_inst (
    .start(start), .hdr(hdr), .nclk(nclk), .sclk(sclk), .din(din), .busy(busy));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one control byte; returns when the host has stopped sclk
  task frame(input logic [3:0] h, input logic [5:0] len);
    @(negedge core_clk);
    hdr   = h;
    nclk  = len;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge core_clk);
  endtask : frame

  task wait_cal(input logic lvl);
    for (k = 0; k < 40 && cal_busy !== lvl; k++) @(negedge core_clk);
  endtask : wait_cal

  // watchdog: the whole sequence needs well under 3000 core clocks
  initial begin
    #300000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = '{4'h8, 6'h18, 16'h1234, 16'h1234, 1'b0};
    rows[1] = '{4'h0, 6'h18, 16'h1234, 16'h9234, 1'b0};
    rows[2] = '{4'hB, 6'h20, 16'hFFFF, 16'hFFFF, 1'b1};
    rows[3] = '{4'h3, 6'h20, 16'h0000, 16'h8000, 1'b1};
    rows[4] = '{4'hA, 6'h20, 16'h00FF, 16'h00FF, 1'b1};
    // sclk must run while the link side is held in reset
    frame(4'h0, 6'h08);
    @(negedge core_clk);
    rst_n = 1'b1;
    chk(16'({serial_strobe_out, result_valid, powered_down, cal_busy}), 16'h0000, "reset");
    frame(4'h0, 6'h03);
    repeat (6) @(negedge core_clk);
    // ordinary conversions; the last row is a shutdown request
    for (n = 0; n < 5; n++) begin
      sample_code = rows[n].code;
      acq_n = 0;
      frame(rows[n].hdr, rows[n].len);
      for (k = 0; k < 20 && result_valid !== 1'b1; k++) @(negedge core_clk);
      chk(result_data, rows[n].exp, "result");
      chk(16'(range_bipolar), 16'(!rows[n].hdr[3]), "range");
      chk(16'(acq_n > 2), 16'(rows[n].lng), "acquisition");
      repeat (2) @(negedge core_clk);
    end
    chk(16'(powered_down), 16'h0001, "software power-down");
    // stalled receiver: two words wait, then leave back to back in order
    result_ready = 1'b0;
    sample_code  = 16'hA5A5;
    frame(4'h8, 6'h18);
    repeat (8) @(negedge core_clk);
    chk(16'(powered_down), 16'h0000, "wake");
    sample_code = 16'h5A5A;
    frame(4'h8, 6'h18);
    repeat (8) @(negedge core_clk);
    chk(result_data, 16'hA5A5, "oldest word");
    result_ready = 1'b1;
    @(negedge core_clk);
    chk(result_data, 16'h5A5A, "second word");
    @(negedge core_clk);
    chk(16'(result_valid), 16'h0000, "drained");
    // internal-clock calibration runs to its end
    frame(4'hD, 6'h05);
    wait_cal(1'b1);
    chk(16'({cal_busy, serial_strobe_out}), 16'h0002, "internal cal");
    wait_cal(1'b0);
    chk(16'(k > 15 && k < 25), 16'h0001, "cal length");
    chk(16'(serial_strobe_out), 16'h0001, "strobe end internal");
    // external-clock calibration cut short by a new start bit
    frame(4'h9, 6'h05);
    wait_cal(1'b1);
    chk(16'(serial_strobe_out), 16'h0001, "external cal");
    // keep the 0.5 us gap after the calibration byte before the next start bit
    repeat (3) @(negedge core_clk);
    frame(4'h8, 6'h18);
    chk(16'(cal_busy), 16'h0000, "start bit abort");
    repeat (10) @(negedge core_clk);
    chk(16'(serial_strobe_out), 16'h0000, "strobe end external");
    // power-down pin aborts calibration and powers down
    frame(4'hD, 6'h05);
    wait_cal(1'b1);
    power_down_pin_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(16'({cal_busy, powered_down}), 16'h0001, "pin abort");
    power_down_pin_n = 1'b1;
    repeat (5) @(negedge core_clk);
    chk(16'(powered_down), 16'h0000, "pin release");
    // reset aborts calibration
    frame(4'hD, 6'h05);
    wait_cal(1'b1);
    rst_n = 1'b0;
    frame(4'h0, 6'h08);
    @(negedge core_clk);
    rst_n = 1'b1;
    chk(16'(cal_busy), 16'h0000, "reset abort");
    complete_run();
  end
endmodule : adc_serial_mode_sequencer_tb
`default_nettype wire

// file: verif/adcms_host.sv
// adcms_host: serial host model that clocks control bytes into the sequencer.
// assumes: the bench raises start with hdr and nclk settled; sclk idles low.
`timescale 1ns/1ns
`default_nettype none

module adcms_host (
  // frame request from the bench
  input  wire logic       start,
  input  wire logic [3:0] hdr,
  input  wire logic [5:0] nclk,
  // serial link
  output logic            sclk,
  output logic            din,
  output logic            busy
);
  int i;

  initial begin
    sclk = 1'b0;
    din  = 1'b0;
    busy = 1'b0;
  end

  // ---------------------------------------------------------------
  // frame: start bit, range, clock source, two mode bits, filler
  // ---------------------------------------------------------------
  // filler toggles every clock so ignored bits never look settled
  always @(posedge start) begin
    busy = 1'b1;
    for (i = 0; i < nclk; i++) begin
      din = (i == 0) ? 1'b1 : (i < 5) ? hdr[4-i] : ~din;
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    din  = ~din;
    busy = 1'b0;
  end
endmodule : adcms_host
`default_nettype wire
